//--- bench/nfs_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------
// array core stand-in: ends each operation
// ---------------------------------------------
module nfs_core_model (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // handshake
  input wire logic busy,
  input wire logic [3:0] lat,
  output logic op_done
);
  int cnt;
  // one done pulse lat cycles into busy
  initial begin
    op_done = 1'b0;
    cnt = 0;
    forever begin
      @(posedge clk);
      #1;
      op_done = 1'b0;
      if (rst || !busy) begin
        cnt = 0;
      end else if (cnt >= 0) begin
        cnt++;
        if (cnt >= lat) begin
          op_done = 1'b1;
          cnt = -1; // hold off until busy drops
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- bench/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import nfs_pkg::*;
  logic clk, rst, feat_wr, feat_rd, quad_req, op_done, res_corr_valid, res_prog_fail;
  logic res_erase_fail, target_locked, block_locked_in, cache_busy;
  logic [7:0] feat_addr, feat_wdata, feat_rdata;
  logic [6:0] pv;
  logic [1:0] res_corr_summary, res_corr_count, drv, e_sum, e_cnt;
  logic [3:0] lat;
  logic feat_rvalid, ecc_en, permit, grant, route, alock, run, wpl, cocc, blk;
  logic [7:0] prot;
  logic e_pf, e_ef, e_wl;
  logic [31:0] seed, s;
  int fails, n_compared;
  // ---------------------------------------------
  // design and core stand-in
  // ---------------------------------------------
  nfs_feature_status dut_u (
    .clk(clk), .rst(rst), .feat_wr(feat_wr), .feat_rd(feat_rd), .feat_addr(feat_addr),
    .feat_wdata(feat_wdata), .feat_rdata(feat_rdata), .feat_rvalid(feat_rvalid),
    .cmd_wr_enable(pv[0]), .cmd_wr_disable(pv[1]), .cmd_soft_reset(pv[2]), .cmd_por(pv[3]),
    .quad_req(quad_req), .op_read(pv[4]), .op_program(pv[5]), .op_erase(pv[6]),
    .op_done(op_done), .res_corr_valid(res_corr_valid), .res_corr_summary(res_corr_summary),
    .res_corr_count(res_corr_count), .res_prog_fail(res_prog_fail),
    .res_erase_fail(res_erase_fail), .target_locked(target_locked),
    .block_locked_in(block_locked_in), .cache_busy(cache_busy), .ecc_enable(ecc_en),
    .quad_io_permit(permit), .quad_grant(grant), .area_route(route),
    .one_time_area_lock(alock), .output_drive_level(drv), .protect_bits(prot),
    .operation_running(run), .write_permit_latch(wpl), .cache_occupied(cocc),
    .selected_block_locked(blk));
  nfs_core_model core_u (.clk(clk), .rst(rst), .busy(run), .lat(lat), .op_done(op_done));
  // clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // ---------------------------------------------
  // helpers
  // ---------------------------------------------
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function logic [7:0] c0e(input logic r);
    return {2'h0, e_sum, e_pf, e_ef, e_wl, r};
  endfunction
  function logic [7:0] f0e(input logic lk, input logic cb);
    return {2'h0, e_cnt, lk, 2'h0, cb};
  endfunction
  task automatic tally_and_finish();
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic cyc();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic fwr(input logic [7:0] a, input logic [7:0] d);
    feat_wr = 1'b1;
    feat_addr = a;
    feat_wdata = d;
    cyc();
    feat_wr = 1'b0;
    cyc();
  endtask
  task automatic frd(input logic [7:0] a, input logic [7:0] e);
    feat_rd = 1'b1;
    feat_addr = a;
    cyc();
    feat_rd = 1'b0;
    chk({7'h0, feat_rvalid}, 8'h01, "rvalid");
    chk(feat_rdata, e, "rdata");
    cyc();
  endtask
  task automatic pulse(input int i, input logic busy);
    pv[i] = 1'b1;
    cyc();
    pv[i] = 1'b0;
    chk({7'h0, run}, {7'h0, busy}, "running");
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (run !== 1'b0 && k < 60) begin
      cyc();
      k++;
    end
    if (run !== 1'b0) begin
      fails++;
      tally_and_finish();
    end
  endtask
  // ---------------------------------------------
  // main sequence
  // ---------------------------------------------
  initial begin
    {feat_wr, feat_rd, pv, quad_req, res_prog_fail, res_erase_fail} = '0;
    {target_locked, cache_busy, feat_addr, feat_wdata} = '0;
    {res_corr_valid, res_corr_summary, res_corr_count, block_locked_in} = 6'h2D;
    {e_sum, e_cnt, e_pf, e_ef, e_wl} = '0;
    lat = 4'h8;
    seed = 32'h95C5;
    fails = 0;
    n_compared = 0;
    rst = 1'b1;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    // boot busy, then page zero result
    frd(8'hC0, 8'h01);
    wait_idle();
    e_sum = 2'h1;
    e_cnt = 2'h2;
    frd(8'hC0, c0e(1'b0));
    frd(8'hF0, f0e(1'b1, 1'b0));
    frd(8'hB0, 8'h10);
    frd(8'hA0, 8'h38);
    frd(8'hD0, 8'h00);
    fwr(8'hC0, 8'hFF);
    fwr(8'hF0, 8'hFF);
    fwr(8'h55, 8'hFF);
    frd(8'hC0, c0e(1'b0));
    frd(8'h55, 8'h00);
    // every drive level, reserved bits masked
    for (int i = 0; i < 4; i++) begin
      s = rnd();
      s[6:5] = i[1:0];
      s[7:0] = s[7:0] & 8'h60;
      fwr(8'hD0, s[7:0]);
      frd(8'hD0, {1'b0, i[1:0], 5'h0});
      chk({6'h0, drv}, {6'h0, i[1:0]}, "drive");
    end
    quad_req = 1'b1;
    cyc();
    chk({7'h0, grant}, 8'h00, "grant");
    fwr(8'hA0, 8'hFF);
    chk(prot, 8'hBE, "prot");
    fwr(8'hB0, 8'hFF);
    frd(8'hB0, 8'hD1);
    chk({4'h0, permit, grant, route, alock}, 8'h0D, "quad");
    fwr(8'hB0, 8'h41);
    chk({6'h0, route, ecc_en}, 8'h02, "area");
    fwr(8'hB0, 8'h10);
    chk({6'h0, grant, ecc_en}, 8'h01, "quad off");
    fwr(8'hB0, 8'h00);
    pulse(4, 1'b1);
    wait_idle();
    {e_sum, e_cnt} = '0;
    frd(8'hC0, c0e(1'b0));
    fwr(8'hB0, 8'h10);
    pulse(0, 1'b0);
    e_wl = 1'b1;
    chk({7'h0, wpl}, 8'h01, "latch");
    frd(8'hC0, c0e(1'b0));
    pulse(1, 1'b0);
    e_wl = 1'b0;
    pulse(5, 1'b0);
    frd(8'hC0, c0e(1'b0));
    pulse(0, 1'b0);
    e_wl = 1'b1;
    // fail flags set, then cleared at next start
    {res_prog_fail, res_erase_fail} = 2'h3;
    for (int i = 5; i < 7; i++) begin
      pulse(i, 1'b1);
      wait_idle();
      e_pf = e_pf | (i == 5);
      e_ef = (i == 6);
      frd(8'hC0, c0e(1'b0));
    end
    {res_prog_fail, res_erase_fail} = 2'h0;
    for (int i = 5; i < 7; i++) begin
      pulse(i, 1'b1);
      if (i == 5) e_pf = 1'b0;
      else e_ef = 1'b0;
      frd(8'hC0, c0e(1'b1));
      wait_idle();
    end
    // locked targets fail with no busy
    target_locked = 1'b1;
    pulse(5, 1'b0);
    pulse(6, 1'b0);
    target_locked = 1'b0;
    {e_pf, e_ef} = 2'h3;
    frd(8'hC0, c0e(1'b0));
    // all summary codes and counts, random latency
    for (int i = 0; i < 8; i++) begin
      s = rnd();
      lat = {1'b0, s[2:0]} + 4'h1;
      res_corr_summary = (i < 4) ? 2'h1 : i[1:0];
      res_corr_count = (i < 4) ? i[1:0] : s[7:6];
      pulse(4, 1'b1);
      wait_idle();
      e_sum = res_corr_summary;
      e_cnt = (e_sum == 2'h1) ? res_corr_count : 2'h0;
      frd(8'hC0, c0e(1'b0));
      frd(8'hF0, f0e(1'b1, 1'b0));
    end
    // soft reset mid-read keeps feature settings
    lat = 4'h8;
    fwr(8'hD0, 8'h40);
    {block_locked_in, cache_busy} = 2'h1;
    pulse(4, 1'b1);
    pulse(2, 1'b1);
    wait_idle();
    {e_sum, e_cnt, e_pf, e_ef, e_wl} = '0;
    frd(8'hC0, c0e(1'b0));
    frd(8'hF0, f0e(1'b0, 1'b1));
    frd(8'hB0, 8'h10);
    frd(8'hD0, 8'h40);
    chk({6'h0, cocc, blk}, 8'h02, "cache");
    // power-on reset restores defaults, loads page zero
    fwr(8'hA0, 8'h00);
    {res_corr_summary, res_corr_count} = 4'hB;
    pulse(3, 1'b1);
    wait_idle();
    e_sum = 2'h2;
    frd(8'hC0, c0e(1'b0));
    frd(8'hA0, 8'h38);
    frd(8'hD0, 8'h00);
    tally_and_finish();
  end
endmodule
`default_nettype wire

//--- hw/nfs_corr_status.sv
`timescale 1ns/1ps
`default_nettype none
module nfs_corr_status
  import nfs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic clear,
  input wire logic load,
  // read result
  input wire logic [1:0] sum_in,
  input wire logic [1:0] cnt_in,
  // stored fields
  output logic [1:0] summary,
  output logic [1:0] count
);
  logic [1:0] next_summary;
  logic [1:0] next_count;

  // ---------------------------------------------
  // field update
  // ---------------------------------------------
  // load wins over clear so a result is never lost
  always_comb begin
    next_summary = summary;
    next_count = count;
    if (clear) begin
      next_summary = 2'h0;
      next_count = 2'h0;
    end
    if (load) begin
      next_summary = sum_in;
      next_count = (nfs_corr_t'(sum_in) == NFS_CORR_FIXED) ? cnt_in : 2'h0;
    end
  end

  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      summary <= 2'h0;
      count <= 2'h0;
    end else begin
      summary <= next_summary;
      count <= next_count;
    end
  end
endmodule
`default_nettype wire

//--- hw/nfs_feature_regs.svh
`ifndef NFS_FEATURE_REGS_SVH
`define NFS_FEATURE_REGS_SVH
// ---------------------------------------------
// feature addresses
// ---------------------------------------------
`define NFS_ADDR_PROT 8'hA0
`define NFS_ADDR_FEAT 8'hB0
`define NFS_ADDR_PRIMARY 8'hC0
`define NFS_ADDR_DRIVE 8'hD0
`define NFS_ADDR_EXTENDED 8'hF0
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define NFS_FEAT_AREA_LOCK 7
`define NFS_FEAT_AREA_SEL 6
`define NFS_FEAT_CORR_EN 4
`define NFS_FEAT_QUAD 0
`define NFS_ST_SUM_LSB 4
`define NFS_ST_PFAIL 3
`define NFS_ST_EFAIL 2
`define NFS_ST_WPL 1
`define NFS_ST_RUN 0
`define NFS_DRV_LSB 5
`define NFS_EX_CNT_LSB 4
`define NFS_EX_LOCKED 3
`define NFS_EX_CACHE 0
// ---------------------------------------------
// reset values and writable masks
// ---------------------------------------------
`define NFS_PROT_RST 8'h38
`define NFS_PROT_MASK 8'hBE
`define NFS_FEAT_RST 8'h10
`define NFS_FEAT_MASK 8'hD1
`define NFS_DRV_RST 2'h0
`endif

//--- hw/nfs_feature_status.sv
`timescale 1ns/1ps
`default_nettype none
`include "nfs_feature_regs.svh"
module nfs_feature_status
  import nfs_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // feature access
  input wire logic feat_wr,
  input wire logic feat_rd,
  input wire logic [7:0] feat_addr,
  input wire logic [7:0] feat_wdata,
  output logic [7:0] feat_rdata,
  output logic feat_rvalid,
  // decoded commands
  input wire logic cmd_wr_enable,
  input wire logic cmd_wr_disable,
  input wire logic cmd_soft_reset,
  input wire logic cmd_por,
  input wire logic quad_req,
  // operation starts and end
  input wire logic op_read,
  input wire logic op_program,
  input wire logic op_erase,
  input wire logic op_done,
  // array results
  input wire logic res_corr_valid,
  input wire logic [1:0] res_corr_summary,
  input wire logic [1:0] res_corr_count,
  input wire logic res_prog_fail,
  input wire logic res_erase_fail,
  input wire logic target_locked,
  input wire logic block_locked_in,
  input wire logic cache_busy,
  // controls to the core
  output logic ecc_enable,
  output logic quad_io_permit,
  output logic quad_grant,
  output logic area_route,
  output logic one_time_area_lock,
  output logic [1:0] output_drive_level,
  output logic [7:0] protect_bits,
  // status
  output logic operation_running,
  output logic write_permit_latch,
  output logic cache_occupied,
  output logic selected_block_locked
);
  // feature and status state
  logic [7:0] prot;
  logic [7:0] feat;
  logic [1:0] drive;
  logic wpl;
  logic pfail;
  logic efail;
  logic running;
  nfs_op_t op_state;
  logic [7:0] next_prot;
  logic [7:0] next_feat;
  logic [1:0] next_drive;
  logic next_wpl;
  logic next_pfail;
  logic next_efail;
  nfs_op_t next_op_state;
  logic corr_clear;
  logic corr_load;
  logic [1:0] corr_summary;
  logic [1:0] corr_count;
  logic prog_blocked;
  // read port and mirrors
  logic [7:0] next_rdata;
  logic [7:0] rdata;
  logic rvalid;
  logic qgrant;
  logic aroute;
  logic cache_q;
  logic locked_q;

  // ---------------------------------------------
  // correction status fields
  // ---------------------------------------------
  nfs_corr_status u_corr (
    .clk(clk),
    .rst(rst),
    .clear(corr_clear),
    .load(corr_load),
    .sum_in(res_corr_summary),
    .cnt_in(res_corr_count),
    .summary(corr_summary),
    .count(corr_count)
  );

  // protected program target, area already locked included
  assign prog_blocked = target_locked |
                        (feat[`NFS_FEAT_AREA_SEL] & feat[`NFS_FEAT_AREA_LOCK]);

  // ---------------------------------------------
  // next feature, status and operation state
  // ---------------------------------------------
  always_comb begin
    next_prot = prot;
    next_feat = feat;
    next_drive = drive;
    next_wpl = wpl;
    next_pfail = pfail;
    next_efail = efail;
    next_op_state = op_state;
    corr_clear = 1'b0;
    corr_load = 1'b0;
    if (feat_wr) begin
      case (feat_addr)
        `NFS_ADDR_PROT: next_prot = feat_wdata & `NFS_PROT_MASK;
        `NFS_ADDR_FEAT: next_feat = feat_wdata & `NFS_FEAT_MASK;
        `NFS_ADDR_DRIVE: next_drive = feat_wdata[`NFS_DRV_LSB +: 2];
        default: ;
      endcase
    end
    if (cmd_wr_disable) begin
      next_wpl = 1'b0;
    end
    if (cmd_wr_enable) begin
      next_wpl = 1'b1;
    end
    unique case (op_state)
      NFS_OP_IDLE: begin
        if (op_read) begin
          corr_clear = 1'b1;
          next_op_state = NFS_OP_READ;
        end else if (op_program && wpl) begin
          if (prog_blocked) begin
            next_pfail = 1'b1;
          end else begin
            next_pfail = 1'b0;
            next_op_state = NFS_OP_PROG;
          end
        end else if (op_erase && wpl) begin
          if (target_locked) begin
            next_efail = 1'b1;
          end else begin
            next_efail = 1'b0;
            next_op_state = NFS_OP_ERASE;
          end
        end
      end
      NFS_OP_READ: begin
        if (op_done) begin
          // no update while correction is off
          corr_load = res_corr_valid & feat[`NFS_FEAT_CORR_EN];
          next_op_state = NFS_OP_IDLE;
        end
      end
      NFS_OP_PROG: begin
        if (op_done) begin
          next_pfail = res_prog_fail;
          next_op_state = NFS_OP_IDLE;
        end
      end
      NFS_OP_ERASE: begin
        if (op_done) begin
          next_efail = res_erase_fail;
          next_op_state = NFS_OP_IDLE;
        end
      end
      NFS_OP_RESET: begin
        if (op_done) begin
          next_op_state = NFS_OP_IDLE;
        end
      end
      NFS_OP_BOOT: begin
        if (op_done) begin
          corr_load = res_corr_valid & feat[`NFS_FEAT_CORR_EN];
          next_op_state = NFS_OP_IDLE;
        end
      end
    endcase
    // soft reset aborts and clears volatile status
    if (cmd_soft_reset || cmd_por) begin
      next_pfail = 1'b0;
      next_efail = 1'b0;
      next_wpl = 1'b0;
      corr_clear = 1'b1;
      corr_load = 1'b0;
      next_op_state = NFS_OP_RESET;
    end
    // power-on reset restores power-up features
    if (cmd_por) begin
      next_prot = `NFS_PROT_RST;
      next_feat = `NFS_FEAT_RST;
      next_drive = `NFS_DRV_RST;
      next_op_state = NFS_OP_BOOT;
    end
  end

  // ---------------------------------------------
  // feature and status registers
  // ---------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      prot <= `NFS_PROT_RST;
      feat <= `NFS_FEAT_RST;
      drive <= `NFS_DRV_RST;
      wpl <= 1'b0;
      pfail <= 1'b0;
      efail <= 1'b0;
      op_state <= NFS_OP_BOOT;
      running <= 1'b1;
    end else begin
      prot <= next_prot;
      feat <= next_feat;
      drive <= next_drive;
      wpl <= next_wpl;
      pfail <= next_pfail;
      efail <= next_efail;
      op_state <= next_op_state;
      running <= (next_op_state != NFS_OP_IDLE);
    end
  end

  // ---------------------------------------------
  // read data mux
  // ---------------------------------------------
  always_comb begin
    next_rdata = 8'h00;
    case (feat_addr)
      `NFS_ADDR_PROT: next_rdata = prot;
      `NFS_ADDR_FEAT: next_rdata = feat;
      `NFS_ADDR_PRIMARY: begin
        next_rdata[`NFS_ST_SUM_LSB +: 2] = corr_summary;
        next_rdata[`NFS_ST_PFAIL] = pfail;
        next_rdata[`NFS_ST_EFAIL] = efail;
        next_rdata[`NFS_ST_WPL] = wpl;
        next_rdata[`NFS_ST_RUN] = running;
      end
      `NFS_ADDR_DRIVE: next_rdata[`NFS_DRV_LSB +: 2] = drive;
      `NFS_ADDR_EXTENDED: begin
        next_rdata[`NFS_EX_CNT_LSB +: 2] = corr_count;
        next_rdata[`NFS_EX_LOCKED] = locked_q;
        next_rdata[`NFS_EX_CACHE] = cache_q;
      end
      default: next_rdata = 8'h00;
    endcase
  end

  // read port and core-facing mirrors
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata <= 8'h00;
      rvalid <= 1'b0;
      qgrant <= 1'b0;
      aroute <= 1'b0;
      cache_q <= 1'b0;
      locked_q <= 1'b1;
    end else begin
      rvalid <= feat_rd;
      if (feat_rd) begin
        rdata <= next_rdata;
      end
      qgrant <= quad_req & feat[`NFS_FEAT_QUAD];
      // area routing while select and unlocked
      aroute <= feat[`NFS_FEAT_AREA_SEL] & ~feat[`NFS_FEAT_AREA_LOCK];
      cache_q <= cache_busy;
      locked_q <= block_locked_in;
    end
  end

  // outputs straight from registers
  assign feat_rdata = rdata;
  assign feat_rvalid = rvalid;
  assign ecc_enable = feat[`NFS_FEAT_CORR_EN];
  assign quad_io_permit = feat[`NFS_FEAT_QUAD];
  assign quad_grant = qgrant;
  assign area_route = aroute;
  assign one_time_area_lock = feat[`NFS_FEAT_AREA_LOCK];
  assign output_drive_level = drive;
  assign protect_bits = prot;
  assign operation_running = running;
  assign write_permit_latch = wpl;
  assign cache_occupied = cache_q;
  assign selected_block_locked = locked_q;

  // ---------------------------------------------
  // checks
  // ---------------------------------------------
  a_read_answer: assert property (@(posedge clk) disable iff (rst)
    feat_rd |=> feat_rvalid ##1 !feat_rvalid || $past(feat_rd))
    else $error("read answer missing");
  a_drive_write: assert property (@(posedge clk) disable iff (rst)
    feat_wr && feat_addr == `NFS_ADDR_DRIVE && !cmd_por
    |=> output_drive_level == $past(feat_wdata[6:5]))
    else $error("drive level not written");
  a_latch_set: assert property (@(posedge clk) disable iff (rst)
    cmd_wr_enable && !cmd_soft_reset && !cmd_por |=> write_permit_latch)
    else $error("write latch not set");
  a_latch_clear: assert property (@(posedge clk) disable iff (rst)
    cmd_wr_disable && !cmd_wr_enable |=> !write_permit_latch)
    else $error("write latch not cleared");
  a_read_busy: assert property (@(posedge clk) disable iff (rst)
    op_state == NFS_OP_IDLE && op_read |=> operation_running && corr_summary == 2'h0)
    else $error("read start not busy or not cleared");
  a_done_ready: assert property (@(posedge clk) disable iff (rst)
    op_state != NFS_OP_IDLE && op_done && !cmd_soft_reset && !cmd_por
    |=> !operation_running)
    else $error("still busy after done");
  a_prog_locked: assert property (@(posedge clk) disable iff (rst)
    op_state == NFS_OP_IDLE && op_program && !op_read && write_permit_latch
    && target_locked && !cmd_soft_reset && !cmd_por |=> pfail && !operation_running)
    else $error("locked program not flagged");
  a_erase_start: assert property (@(posedge clk) disable iff (rst)
    op_state == NFS_OP_IDLE && op_erase && !op_read && !op_program
    && write_permit_latch && !target_locked && !cmd_soft_reset && !cmd_por
    |=> !efail && operation_running)
    else $error("erase start wrong");
  a_soft_keep: assert property (@(posedge clk) disable iff (rst)
    cmd_soft_reset && !cmd_por && !feat_wr
    |=> $stable(ecc_enable) && $stable(output_drive_level) && !pfail && !efail)
    else $error("soft reset changed features");
  a_reserved_zero: assert property (@(posedge clk) disable iff (rst)
    feat_rvalid && $past(feat_addr) == `NFS_ADDR_PRIMARY |-> feat_rdata[7:6] == 2'h0)
    else $error("reserved status bits set");
endmodule
`default_nettype wire

//--- hw/nfs_pkg.sv
package nfs_pkg;
  // array operation in progress
  typedef enum logic [2:0] {
    NFS_OP_IDLE,
    NFS_OP_READ,
    NFS_OP_PROG,
    NFS_OP_ERASE,
    NFS_OP_RESET,
    NFS_OP_BOOT
  } nfs_op_t;
  // correction summary codes, in code order
  typedef enum logic [1:0] {
    NFS_CORR_NONE,
    NFS_CORR_FIXED,
    NFS_CORR_FAIL,
    NFS_CORR_RSVD
  } nfs_corr_t;
endpackage
